/* include/slave_id_defines.vh */
// Register offsets, field positions and reset values for the identity bank
// How it works
// - Sixteen-bit feature word is read-only on both ports; bit 0 mapping granularity.
// - Feature bit 1 set means unused register access is not supported.
// - Bit 2 reports time unit present; bit 3 gives 32 or 64 bit width.
// - Bits 4 to 6 report low-jitter link and enhanced link detection capabilities.
// - Bit 7 reports separate counting of bad-FCS frames with an extra nibble.
// - Bit 8 reports enhanced synchronization signal activation is implemented.
// - Bit 9 is inverted: zero means logical read-write command is supported.
// - Bit 10 zero means broadcast, auto-increment and fixed read-write are supported.
// - Bit 11 one means fixed mapping configuration; bits 15:14 read zero.
// - Station address resets to zero, network writable, port read-only, used for matching.
// - Alias is port writable, network read-only, matched only when control bit 24 set.
// - Alias reads zero until first EEPROM load, then word 4; reloads ignored.
// - Under protection, a write enable earlier in the frame unlocks further register writes.
// - Write enable clears at next frame start or when protection is disabled.
// - Protection bit 0 at 0x0021 guards 0x0000 to 0x0F7F except enables.
`ifndef SLAVE_ID_DEFINES_VH
`define SLAVE_ID_DEFINES_VH
`define ADDR_W 16
`define OFF_FEATURE_LO 16'h0008
`define OFF_FEATURE_HI 16'h0009
`define OFF_STADDR_LO 16'h0010
`define OFF_STADDR_HI 16'h0011
`define OFF_ALIAS_LO 16'h0012
`define OFF_ALIAS_HI 16'h0013
`define OFF_WR_ENABLE 16'h0020
`define OFF_WR_PROTECT 16'h0021
`define OFF_DEV_WR_ENABLE 16'h0030
`define PROT_LAST 16'h0F7F
`define BIT_PROTECT_EN 0
`define BIT_WR_ENABLE 0
`define BIT_ALIAS_ACTIVE 24
`define ALIAS_EEPROM_WORD 8'h04
`define FEAT_RESERVED_MASK 16'hC000
`define STADDR_RESET 16'h0000
`define ALIAS_RESET 16'h0000
`define BYTE_ZERO 8'h00
`define FEAT_BIT_GRAN 0
`define FEAT_BIT_UNUSED 1
`define FEAT_BIT_TIME 2
`define FEAT_BIT_TIME64 3
`define FEAT_BIT_LOWJIT 4
`define FEAT_BIT_LINKDET 5
`define FEAT_BIT_MIIDET 6
`define FEAT_BIT_FCS 7
`define FEAT_BIT_SYNC 8
`define FEAT_BIT_LOGIC_RW 9
`define FEAT_BIT_RW 10
`define FEAT_BIT_FIXED 11
`endif

/* verilog/feature_word.v */
// Constant feature capability word assembled from parameters
`timescale 1ns/1ns
`default_nettype none
`include "slave_id_defines.vh"
module feature_word
#(
   parameter [0:0] byte_granular = 1'b0,
   parameter [0:0] unused_access_refused = 1'b0,
   parameter [0:0] time_unit_present = 1'b1,
   parameter [0:0] time_unit_64bit = 1'b0,
   parameter [0:0] low_jitter_link = 1'b0,
   parameter [0:0] link_detect_low_voltage = 1'b0,
   parameter [0:0] link_detect_mii = 1'b0,
   parameter [0:0] fcs_separate = 1'b0,
   parameter [0:0] sync_activation = 1'b0,
   parameter [0:0] logical_rw_unsupported = 1'b0,
   parameter [0:0] rw_cmds_unsupported = 1'b0,
   parameter [0:0] fixed_mapping = 1'b0,
   parameter [1:0] bits_13_12 = 2'b00
)
(
   output wire [15:0] feature
);
   assign feature[`FEAT_BIT_GRAN] = byte_granular;
   assign feature[`FEAT_BIT_UNUSED] = unused_access_refused;
   assign feature[`FEAT_BIT_TIME] = time_unit_present;
   assign feature[`FEAT_BIT_TIME64] = time_unit_64bit;
   assign feature[`FEAT_BIT_LOWJIT] = low_jitter_link;
   assign feature[`FEAT_BIT_LINKDET] = link_detect_low_voltage;
   assign feature[`FEAT_BIT_MIIDET] = link_detect_mii;
   assign feature[`FEAT_BIT_FCS] = fcs_separate;
   assign feature[`FEAT_BIT_SYNC] = sync_activation;
   assign feature[`FEAT_BIT_LOGIC_RW] = logical_rw_unsupported;
   assign feature[`FEAT_BIT_RW] = rw_cmds_unsupported;
   assign feature[`FEAT_BIT_FIXED] = fixed_mapping;
   assign feature[13:12] = bits_13_12;
   assign feature[15:14] = 2'b00;
endmodule
`default_nettype wire

/* verilog/addr_match.v */
// Fixed-address match against station address or alias
`timescale 1ns/1ns
`default_nettype none
`include "slave_id_defines.vh"
module addr_match
(
   input wire [15:0] frame_addr,
   input wire [15:0] station_addr,
   input wire [15:0] station_alias,
   input wire alias_active,
   output wire hit
);
   assign hit = (frame_addr == station_addr) ||
      (alias_active && (frame_addr == station_alias));
endmodule
`default_nettype wire

/* verilog/slave_id_address_regs.v */
// Identity, station address, alias and write enable register bank
`timescale 1ns/1ns
`default_nettype none
`include "slave_id_defines.vh"
module slave_id_address_regs
#(
   parameter [0:0] byte_granular = 1'b0,
   parameter [0:0] unused_access_refused = 1'b0,
   parameter [0:0] time_unit_present = 1'b1,
   parameter [0:0] time_unit_64bit = 1'b0,
   parameter [0:0] low_jitter_link = 1'b0,
   parameter [0:0] link_detect_low_voltage = 1'b0,
   parameter [0:0] link_detect_mii = 1'b0,
   parameter [0:0] fcs_separate = 1'b0,
   parameter [0:0] sync_activation = 1'b0,
   parameter [0:0] logical_rw_unsupported = 1'b0,
   parameter [0:0] rw_cmds_unsupported = 1'b0,
   parameter [0:0] fixed_mapping = 1'b0
)
(
   input wire clk,
   input wire rst_b,
   input wire frame_start,
   input wire [15:0] net_addr,
   input wire net_wr,
   input wire [7:0] net_wdata,
   input wire net_rd,
   output reg [7:0] net_rdata,
   output wire net_wr_refused,
   input wire [15:0] port_addr,
   input wire port_wr,
   input wire [7:0] port_wdata,
   input wire port_rd,
   output reg [7:0] port_rdata,
   input wire protect_en,
   input wire [31:0] link_control,
   input wire eeprom_load_done,
   input wire [7:0] eeprom_word_index,
   input wire [15:0] eeprom_word,
   input wire [15:0] fixed_cmd_addr,
   output wire fixed_addr_hit,
   output wire [15:0] station_address,
   output wire [15:0] station_alias,
   output wire write_enable
);
   wire [15:0] feature;
   reg [15:0] staddr_reg;
   reg [15:0] alias_reg;
   reg alias_loaded_reg;
   reg wr_en_reg;
   reg [7:0] net_rdata_next;
   reg [7:0] port_rdata_next;
   wire net_prot_area;
   wire net_is_enable;
   wire net_wr_ok;

   feature_word
   #(
      .byte_granular(byte_granular),
      .unused_access_refused(unused_access_refused),
      .time_unit_present(time_unit_present),
      .time_unit_64bit(time_unit_64bit),
      .low_jitter_link(low_jitter_link),
      .link_detect_low_voltage(link_detect_low_voltage),
      .link_detect_mii(link_detect_mii),
      .fcs_separate(fcs_separate),
      .sync_activation(sync_activation),
      .logical_rw_unsupported(logical_rw_unsupported),
      .rw_cmds_unsupported(rw_cmds_unsupported),
      .fixed_mapping(fixed_mapping),
      .bits_13_12(2'b00)
   )
   u_feature
   (
      .feature(feature)
   );

   addr_match u_match
   (
      .frame_addr(fixed_cmd_addr),
      .station_addr(staddr_reg),
      .station_alias(alias_reg),
      .alias_active(link_control[`BIT_ALIAS_ACTIVE]),
      .hit(fixed_addr_hit)
   );

   // Shared readback, used by both ports
   function [7:0] read_byte;
      input [15:0] a;
      input [15:0] feat;
      input [15:0] sa;
      input [15:0] al;
      input we;
      input pe;
      begin
         if (a == `OFF_FEATURE_LO)
            read_byte = feat[7:0];
         else if (a == `OFF_FEATURE_HI)
            read_byte = feat[15:8];
         else if (a == `OFF_STADDR_LO)
            read_byte = sa[7:0];
         else if (a == `OFF_STADDR_HI)
            read_byte = sa[15:8];
         else if (a == `OFF_ALIAS_LO)
            read_byte = al[7:0];
         else if (a == `OFF_ALIAS_HI)
            read_byte = al[15:8];
         else if (a == `OFF_WR_ENABLE)
            read_byte = {7'b000_0000, we};
         else if (a == `OFF_WR_PROTECT)
            read_byte = {7'b000_0000, pe};
         else
            read_byte = `BYTE_ZERO;
      end
   endfunction

   assign net_prot_area = (net_addr <= `PROT_LAST);
   assign net_is_enable = (net_addr == `OFF_WR_ENABLE) ||
      (net_addr == `OFF_DEV_WR_ENABLE);
   assign net_wr_ok = !protect_en || wr_en_reg || !net_prot_area || net_is_enable;
   assign net_wr_refused = net_wr && !net_wr_ok;

   // Network-side writes
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         staddr_reg <= `STADDR_RESET;
      end
      else if (net_wr && net_wr_ok)
      begin
         if (net_addr == `OFF_STADDR_LO)
            staddr_reg[7:0] <= net_wdata;
         else if (net_addr == `OFF_STADDR_HI)
            staddr_reg[15:8] <= net_wdata;
      end
   end

   // Write enable flag; set wins over frame-start clear in the same cycle
   always @(posedge clk)
   begin
      if (!rst_b)
         wr_en_reg <= 1'b0;
      else if (!protect_en)
         wr_en_reg <= 1'b0;
      else if (net_wr && (net_addr == `OFF_WR_ENABLE))
         wr_en_reg <= 1'b1;
      else if (frame_start)
         wr_en_reg <= 1'b0;
   end

   // Alias: port writes and one-time EEPROM load
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         alias_reg <= `ALIAS_RESET;
         alias_loaded_reg <= 1'b0;
      end
      else
      begin
         if (port_wr && (port_addr == `OFF_ALIAS_LO))
            alias_reg[7:0] <= port_wdata;
         else if (port_wr && (port_addr == `OFF_ALIAS_HI))
            alias_reg[15:8] <= port_wdata;
         else if (eeprom_load_done && !alias_loaded_reg &&
            (eeprom_word_index == `ALIAS_EEPROM_WORD))
            alias_reg <= eeprom_word;
         if (eeprom_load_done)
            alias_loaded_reg <= 1'b1;
      end
   end

   // Registered read data, one cycle after the strobe
   always @*
   begin
      net_rdata_next = net_rdata;
      port_rdata_next = port_rdata;
      if (net_rd)
         net_rdata_next = read_byte(net_addr, feature, staddr_reg, alias_reg,
            wr_en_reg, protect_en);
      if (port_rd)
         port_rdata_next = read_byte(port_addr, feature, staddr_reg, alias_reg,
            wr_en_reg, protect_en);
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         net_rdata <= `BYTE_ZERO;
         port_rdata <= `BYTE_ZERO;
      end
      else
      begin
         net_rdata <= net_rdata_next;
         port_rdata <= port_rdata_next;
      end
   end

   assign station_address = staddr_reg;
   assign station_alias = alias_reg;
   assign write_enable = wr_en_reg;
endmodule
`default_nettype wire

/* verification/eeprom_model.sv */
// Configuration memory model delivering alias word loads
`timescale 1ns/1ns
`default_nettype none
module eeprom_model
(
   input wire logic clk,
   input wire logic req,
   input wire logic [15:0] word4,
   output logic done,
   output logic [7:0] index,
   output logic [15:0] word
);
   initial
   begin
      done = 1'b0;
      index = 8'h00;
      word = 16'h0000;
   end
   always @(posedge clk)
   begin
      done <= req;
      // Churn outside loads so stale data never looks valid
      index <= req ? 8'h04 : index + 8'h01;
      word <= req ? word4 : ~word;
   end
endmodule
`default_nettype wire

/* verification/slave_id_address_regs_sva.sv */
// Assertion checker for the identity register bank
`timescale 1ns/1ns
`default_nettype none
module slave_id_address_regs_chk
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic frame_start,
   input wire logic [15:0] net_addr,
   input wire logic net_wr,
   input wire logic [7:0] net_wdata,
   input wire logic net_rd,
   input wire logic [7:0] net_rdata,
   input wire logic net_wr_refused,
   input wire logic protect_en,
   input wire logic [31:0] link_control,
   input wire logic [15:0] fixed_cmd_addr,
   input wire logic fixed_addr_hit,
   input wire logic [15:0] station_address,
   input wire logic [15:0] station_alias,
   input wire logic write_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_refuse_cond: assert property (net_wr_refused == (net_wr && protect_en
      && !write_enable && net_addr <= 16'h0F7F && net_addr != 16'h0020 && net_addr != 16'h0030))
      else $error("refusal flag wrong");
   chk_refused_kept: assert property (net_wr_refused |=> $stable(station_address))
      else $error("refused write landed");
   chk_staddr_write: assert property (net_wr && !net_wr_refused && net_addr == 16'h0010
      |=> station_address[7:0] == $past(net_wdata)) else $error("address write lost");
   chk_we_unprot: assert property (!protect_en ##1 !protect_en |-> !write_enable)
      else $error("enable kept unprotected");
   chk_we_sof: assert property (frame_start && !(net_wr && net_addr == 16'h0020)
      |=> !write_enable) else $error("enable kept past frame");
   chk_we_set: assert property (net_wr && protect_en && net_addr == 16'h0020
      |=> write_enable) else $error("enable not set");
   chk_hit_match: assert property (fixed_addr_hit == (fixed_cmd_addr == station_address
      || (link_control[24] && fixed_cmd_addr == station_alias))) else $error("match wrong");
   chk_feat_resv: assert property (net_rd && net_addr == 16'h0009
      |=> net_rdata[7:6] == 2'b00) else $error("reserved bits set");
   cov_refused: cover property (net_wr_refused);
   cov_alias_hit: cover property (link_control[24] && fixed_addr_hit);
   cov_sof: cover property (frame_start && write_enable);
   cov_set_sof: cover property (frame_start && protect_en && net_wr && net_addr == 16'h0020);
endmodule
bind slave_id_address_regs slave_id_address_regs_chk chk (.clk, .rst_b, .frame_start, .net_addr,
   .net_wr, .net_wdata, .net_rd, .net_rdata, .net_wr_refused, .protect_en, .link_control,
   .fixed_cmd_addr, .fixed_addr_hit, .station_address, .station_alias, .write_enable);
`default_nettype wire

/* verification/slave_id_address_regs_tb.sv */
// Self-checking bench for the identity register bank
`timescale 1ns/1ns
`default_nettype none
module slave_id_address_regs_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic frame_start = 1'b0;
   logic [15:0] net_addr = 16'h0000;
   logic net_wr = 1'b0;
   logic [7:0] net_wdata = 8'h00;
   logic net_rd = 1'b0;
   logic [15:0] port_addr = 16'h0000;
   logic port_wr = 1'b0;
   logic [7:0] port_wdata = 8'h00;
   logic port_rd = 1'b0;
   logic protect_en = 1'b0;
   logic [31:0] link_control = 32'h0000_0000;
   logic [15:0] fixed_cmd_addr = 16'h0000;
   logic ee_req = 1'b0;
   logic [15:0] ee_val = 16'h0000;
   logic refused_seen;
   wire [7:0] net_rdata, port_rdata, ee_index;
   wire [15:0] ee_word, station_address, station_alias;
   wire net_wr_refused, fixed_addr_hit, write_enable, ee_done;
   int mismatches = 0;
   int num_checks = 0;
   always #20 clk = ~clk;
   eeprom_model ee (.clk(clk), .req(ee_req), .word4(ee_val), .done(ee_done), .index(ee_index),
      .word(ee_word));
   slave_id_address_regs dut (.clk(clk), .rst_b(rst_b), .frame_start(frame_start),
      .net_addr(net_addr), .net_wr(net_wr), .net_wdata(net_wdata), .net_rd(net_rd),
      .net_rdata(net_rdata), .net_wr_refused(net_wr_refused), .port_addr(port_addr),
      .port_wr(port_wr), .port_wdata(port_wdata), .port_rd(port_rd), .port_rdata(port_rdata),
      .protect_en(protect_en), .link_control(link_control), .eeprom_load_done(ee_done),
      .eeprom_word_index(ee_index), .eeprom_word(ee_word), .fixed_cmd_addr(fixed_cmd_addr),
      .fixed_addr_hit(fixed_addr_hit), .station_address(station_address),
      .station_alias(station_alias), .write_enable(write_enable));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic nwr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      net_addr = a;
      net_wdata = d;
      net_wr = 1'b1;
      #1 refused_seen = net_wr_refused;
      @(negedge clk);
      net_wr = 1'b0;
   endtask
   task automatic pwr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      port_addr = a;
      port_wdata = d;
      port_wr = 1'b1;
      @(negedge clk);
      port_wr = 1'b0;
   endtask
   task automatic rd(input logic net, input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      net_addr = a;
      port_addr = a;
      net_rd = net;
      port_rd = !net;
      @(negedge clk);
      net_rd = 1'b0;
      port_rd = 1'b0;
      check(net ? net_rdata : port_rdata, {8'h00, e});
   endtask
   task automatic ee_load(input logic [15:0] v);
      @(negedge clk);
      ee_val = v;
      ee_req = 1'b1;
      @(negedge clk);
      ee_req = 1'b0;
      @(negedge clk);
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      wrap_up;
   end
   initial
   begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      check(station_address, 16'h0000);
      check(station_alias, 16'h0000);
      nwr(16'h0008, 8'hFF);
      pwr(16'h0009, 8'hFF);
      rd(1'b1, 16'h0008, 8'h04);
      rd(1'b0, 16'h0008, 8'h04);
      rd(1'b1, 16'h0009, 8'h00);
      rd(1'b0, 16'h0009, 8'h00);
      $display("Test feature done");
      nwr(16'h0010, 8'h34);
      nwr(16'h0011, 8'h12);
      pwr(16'h0010, 8'h55);
      check(station_address, 16'h1234);
      rd(1'b0, 16'h0011, 8'h12);
      $display("Test address done");
      ee_load(16'hBEEF);
      check(station_alias, 16'hBEEF);
      ee_load(16'h1111);
      check(station_alias, 16'hBEEF);
      nwr(16'h0012, 8'h00);
      pwr(16'h0012, 8'h77);
      check(station_alias, 16'hBE77);
      rd(1'b1, 16'h0013, 8'hBE);
      $display("Test alias done");
      @(negedge clk);
      fixed_cmd_addr = 16'h1234;
      #1 check(fixed_addr_hit, 16'h0001);
      fixed_cmd_addr = 16'hBE77;
      #1 check(fixed_addr_hit, 16'h0000);
      link_control = 32'h0100_0000;
      #1 check(fixed_addr_hit, 16'h0001);
      $display("Test match done");
      protect_en = 1'b1;
      nwr(16'h0010, 8'hAA);
      check(refused_seen, 16'h0001);
      check(station_address, 16'h1234);
      nwr(16'h0020, 8'h5A);
      check(refused_seen, 16'h0000);
      rd(1'b1, 16'h0020, 8'h01);
      nwr(16'h0010, 8'hAA);
      check(station_address, 16'h12AA);
      frame_start = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
      check(write_enable, 16'h0000);
      nwr(16'h0011, 8'h99);
      check(station_address, 16'h12AA);
      nwr(16'h0030, 8'h00);
      check(refused_seen, 16'h0000);
      // Enable write and frame start in one cycle: set wins
      fork
         nwr(16'h0020, 8'h00);
         begin
            @(negedge clk);
            frame_start = 1'b1;
            @(negedge clk);
            frame_start = 1'b0;
         end
      join
      check(write_enable, 16'h0001);
      protect_en = 1'b0;
      repeat (2) @(negedge clk);
      check(write_enable, 16'h0000);
      rd(1'b1, 16'h0040, 8'h00);
      $display("Test protection done");
      @(negedge clk);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      check(station_alias, 16'h0000);
      check(station_address, 16'h0000);
      ee_load(16'hCAFE);
      check(station_alias, 16'hCAFE);
      $display("Test reset reload done");
      wrap_up;
   end
endmodule
`default_nettype wire
